// ===== hdl/egu_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
// One sticky fired-event flag; a fire in the clearing cycle wins
module egu_flag_bit (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_fire,
  input wire logic i_clr,
  output logic o_flag
);
  logic flag_q;
  logic flag_d;
  assign flag_d = i_fire | (flag_q & ~i_clr);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
  assign o_flag = flag_q;
endmodule
`default_nettype wire

// ===== hdl/egu_irq_reg.sv
`timescale 1ns/1ps
`default_nettype none
// Sixteen interrupt enables with direct, set and clear write views
module egu_irq_reg (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_direct,
  input wire logic i_wr_set,
  input wire logic i_wr_clr,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_enable
);
  logic [15:0] en_q;
  logic [15:0] en_d;
  assign en_d = i_wr_direct ? i_wdata :
                i_wr_set ? (en_q | i_wdata) :
                i_wr_clr ? (en_q & ~i_wdata) : en_q;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      en_q <= egu_pkg::RST_IRQ_EN;
    end else begin
      en_q <= en_d;
    end
  end
  assign o_enable = en_q;
endmodule
`default_nettype wire

// ===== hdl/egu_pkg.sv
package egu_pkg;
  localparam int NUM_EVT = 16;
  localparam logic [11:0] OFF_TRIGGER_BASE = 12'h000;
  localparam logic [11:0] OFF_TRIGGER_LAST = 12'h03c;
  localparam logic [11:0] OFF_FLAG_BASE = 12'h100;
  localparam logic [11:0] OFF_FLAG_LAST = 12'h13c;
  localparam logic [11:0] OFF_IRQ_EN = 12'h300;
  localparam logic [11:0] OFF_IRQ_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
  localparam logic [15:0] RST_IRQ_EN = 16'h0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  localparam int IRQ_LATENCY_CYC = 1;
endpackage

// ===== hdl/egu_top.sv
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Writing 1 to an enable-set bit turns that event's interrupt enable on; partial-word writes are ignored.
// - Writing 1 to an enable-clear bit turns that event's interrupt enable off; partial-word writes are ignored.
// - Reading enable-set or enable-clear returns current enables, same positions.
// - Enables sit in bits 0 to 15, bit n for event n; upper bits read zero.
// - After reset all sixteen enables are cleared.
// - Firing trigger task n sets fired-event flag n; sixteen pairs exist.
// - Combined enable register writes enables directly and mirrors set/clear views; partial-word writes are ignored.
// - Interrupt rises one clock after an enabled fired-event flag sets.
module egu_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [11:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [15:0] i_trigger,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [15:0] o_fired_event,
  output logic o_irq
);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: every access takes exactly one wait cycle
  typedef enum logic [1:0] {
    EGU_IDLE = 2'b00,
    EGU_ACK = 2'b01
  } egu_state_e;

  egu_state_e state_q;
  egu_state_e state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic [15:0] enable;
  logic [15:0] flag;
  wire req = i_avs_read | i_avs_write;
  wire accept = req & (state_q == EGU_ACK);
  wire wr_acc = accept & i_avs_write;
  wire full_word = &i_avs_byteenable;
  wire [15:0] wdata16 = i_avs_writedata[15:0];
  wire [11:0] addr = {i_avs_address[11:2], 2'b00};
  wire hit_en = addr == egu_pkg::OFF_IRQ_EN;
  wire hit_set = addr == egu_pkg::OFF_IRQ_SET;
  wire hit_clr = addr == egu_pkg::OFF_IRQ_CLR;
  wire hit_trig = (addr >= egu_pkg::OFF_TRIGGER_BASE) && (addr <= egu_pkg::OFF_TRIGGER_LAST);
  wire hit_flag = (addr >= egu_pkg::OFF_FLAG_BASE) && (addr <= egu_pkg::OFF_FLAG_LAST);
  wire [3:0] idx = addr[5:2];
  wire [15:0] idx_dec = 16'h0001 << idx;
  // Partial-word writes to enable views ignored to keep fields atomic
  wire wr_en = wr_acc & full_word & hit_en;
  wire wr_set = wr_acc & full_word & hit_set;
  wire wr_clr = wr_acc & full_word & hit_clr;
  // Task write of 1 in bit 0 fires; flag write of 0 clears
  wire [15:0] sw_fire = (wr_acc & hit_trig & i_avs_writedata[0]) ? idx_dec : 16'h0000;
  wire [15:0] sw_clr = (wr_acc & hit_flag & ~i_avs_writedata[0]) ? idx_dec : 16'h0000;
  wire [15:0] fire = sw_fire | i_trigger;

  ////////////////////////////////////////////////////////////////////////////////
  // Enables and flags
  egu_irq_reg u_en (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_wr_direct(wr_en),
    .i_wr_set(wr_set),
    .i_wr_clr(wr_clr),
    .i_wdata(wdata16),
    .o_enable(enable)
  );

  genvar g;
  generate
    for (g = 0; g < egu_pkg::NUM_EVT; g++) begin : g_flag
      egu_flag_bit u_flag (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_fire(fire[g]),
        .i_clr(sw_clr[g]),
        .o_flag(flag[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; all three enable views read the same state
  wire [31:0] rd_en = {16'h0000, enable};
  wire [31:0] rd_flag = {31'h0000_0000, flag[idx]};
  assign rdata_d = (hit_en | hit_set | hit_clr) ? rd_en :
                   hit_flag ? rd_flag : egu_pkg::RD_UNMAPPED;

  always_comb begin
    case (state_q)
      EGU_IDLE: state_d = req ? EGU_ACK : EGU_IDLE;
      EGU_ACK: state_d = EGU_IDLE;
      default: state_d = EGU_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= EGU_IDLE;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      irq_q <= |(flag & enable);
    end
  end

  // Read data registered in IDLE, stands at the accepting edge
  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = ~(state_q == EGU_ACK);
  assign o_fired_event = flag;
  assign o_irq = irq_q;
endmodule
`default_nettype wire

// ===== tb/egu_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module egu_top_sva (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [11:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [15:0] i_trigger,
  input wire logic o_avs_waitrequest,
  input wire logic [15:0] o_fired_event,
  input wire logic o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wr(a);
    i_avs_write && !o_avs_waitrequest && i_avs_address == a && i_avs_writedata[15:0] == '1
      && &i_avs_byteenable;
  endsequence
  // Irq is registered, so it trails the enable change by one more edge
  property p_set; s_wr(12'h304) ##0 o_fired_event != '0 |=> ##1 o_irq; endproperty
  a_set: assert property (p_set) else $error("irq stayed low");
  property p_clr; s_wr(12'h308) |=> ##1 !o_irq; endproperty
  a_clr: assert property (p_clr) else $error("irq stayed high");
  property p_ack; (i_avs_write || i_avs_read) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("no accept");
  property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("accept too long");
  property p_rst; $rose(i_rst_n) |-> o_fired_event == '0 && !o_irq; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_zero; o_fired_event == '0 |=> !o_irq; endproperty
  a_zero: assert property (p_zero) else $error("irq without flag");
  property p_fire; i_trigger[15] |=> o_fired_event[15]; endproperty
  a_fire: assert property (p_fire) else $error("flag not set");
  property p_keep; o_fired_event[0] && !i_avs_write |=> o_fired_event[0]; endproperty
  a_keep: assert property (p_keep) else $error("flag lost");
endmodule
bind egu_top egu_top_sva u_sva (.*);
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0, o_irq;
  logic o_avs_waitrequest;
  logic [11:0] i_avs_address = '0;
  logic [31:0] i_avs_writedata = '0, o_avs_readdata, q[$];
  logic [3:0] i_avs_byteenable = 4'hf;
  logic [15:0] i_trigger = '0, o_fired_event, en = '0, r = 16'h2328;
  int n_fail = 0, comparisons = 0, cyc = 0;
  egu_top dut (.*);
  always #5 i_sys_clk = ~i_sys_clk;
  function automatic logic [15:0] lf(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task complete_run;
    n_fail += int'(cyc >= 3000);
    if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read data is judged at the accept edge only; nothing holds it after
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) complete_run();
    if (i_avs_read && o_avs_waitrequest === 1'b0) begin
      comparisons++;
      if (o_avs_readdata !== q[0]) begin
        n_fail++;
        $display("MISMATCH %0t %h %h", $time, o_avs_readdata, q[0]);
      end
      void'(q.pop_front());
    end
  end
  // Irq is registered after the enable update, so it settles one edge after accept and is read at the second
  task automatic chk_irq(logic e);
    repeat (2) @(posedge i_sys_clk);
    comparisons++;
    if (o_irq !== e) begin
      n_fail++;
      $display("MISMATCH %0t %h %h", $time, o_irq, e);
    end
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d, logic [31:0] e);
    @(posedge i_sys_clk);
    if (!w) q.push_back(e);
    {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} <= {!w, w, a, d};
    do @(posedge i_sys_clk); while (o_avs_waitrequest !== 1'b0);
    {i_avs_read, i_avs_write} <= 2'h0;
  endtask
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      r = lf(r);
      en = k[0] ? en & ~r : en | r;
      bus(1'b1, k[0] ? 12'h308 : 12'h304, {16'hffff, r}, '0);
      bus(1'b0, k[0] ? 12'h304 : 12'h308, '0, {16'h0, en});
    end
    bus(1'b1, 12'h300, 32'h0000a5c3, '0);
    bus(1'b0, 12'h308, '0, 32'h0000a5c3);
    bus(1'b0, 12'h200, '0, '0);
    en = r | 16'h8001;
    i_trigger <= en;
    @(posedge i_sys_clk);
    i_trigger <= '0;
    bus(1'b1, 12'h304, 32'h0000ffff, '0);
    chk_irq(1'b1);
    bus(1'b1, 12'h308, 32'h0000ffff, '0);
    chk_irq(1'b0);
    for (int k = 0; k < 16; k++) begin
      bus(1'b0, 12'h100 + 12'(4 * k), '0, {31'h0, en[k]});
      bus(1'b1, 12'h100 + 12'(4 * k), '0, '0);
    end
    bus(1'b1, 12'h03c, 32'h00000001, '0);
    bus(1'b0, 12'h13c, '0, 32'h00000001);
    bus(1'b0, 12'h100, '0, 32'h00000000);
    complete_run();
  end
endmodule
`default_nettype wire
